// ### src/prm_map.vh
`ifndef PRM_MAP_VH
`define PRM_MAP_VH
// register byte offsets
`define PRM_OFS_PORTE_DATA   12'h000
`define PRM_OFS_PORTE_DIR    12'h004
`define PRM_OFS_PORTT_DATA   12'h008
`define PRM_OFS_PORTT_DIR    12'h00C
`define PRM_OFS_PORTS_DATA   12'h010
`define PRM_OFS_PORTS_DIR    12'h014
`define PRM_OFS_PORTP_DATA   12'h018
`define PRM_OFS_PORTP_DIR    12'h01C
`define PRM_OFS_PORTA_DATA   12'h020
`define PRM_OFS_PORTA_DIR    12'h024
`define PRM_OFS_PULL_EN      12'h028
`define PRM_OFS_PULL_UP      12'h02C
`define PRM_OFS_MISC_CTRL    12'h030
`define PRM_OFS_ROUTE        12'h034
`define PRM_OFS_INT_FLAG     12'h038
`define PRM_OFS_INT_MASK     12'h03C
`define PRM_OFS_INT_EDGE     12'h040
`define PRM_OFS_PIN_IN       12'h044
`define PRM_OFS_STATUS       12'h048
// pull register packing: t[3:0] s[9:4] p[15:10] ad[21:16]
`define PRM_PULL_T_LSB       0
`define PRM_PULL_S_LSB       4
`define PRM_PULL_P_LSB       10
`define PRM_PULL_A_LSB       16
// misc control fields
`define PRM_MISC_PE_PULL     0
`define PRM_MISC_DBG_PULL    1
`define PRM_MISC_OPEN_DRAIN  2
`define PRM_MISC_REDUCED_DRV 8
`define PRM_MISC_CLK_OUT     9
`define PRM_MISC_OSC_EN      10
// route fields
`define PRM_RT_SPI_T         0
`define PRM_RT_LIN_T         1
`define PRM_RT_LINDRV_T1     2
`define PRM_RT_SCI0_T        3
// interrupt packing: p[5:0] l[9:6] ad[15:10]
`define PRM_INT_W            16
// reset values
`define PRM_RST_MISC         11'h003
`define PRM_RST_PULL_EN      22'h000000
`define PRM_RST_PULL_UP      22'h000000
// glitch filter length in bus cycles
`define PRM_FILT_CYC         4
`endif

// ### src/prm_pin_routing.v
`timescale 1ns/100ps
`include "prm_map.vh"

// Function
// - shared pin output from highest ranked function
// - routed functions used only when routing selects
// - debug pin samples mode level during reset
// - debug pin is bidirectional single wire
// - port E GPIO; oscillator overrides
// - port T GPIO; routed SPI/LIN above timer
// - T1 order lindrv, sci0 tx, pulse_chan7, tim1, gpio
// - T0 order sci0 rx, pulse_chan6, tim0, gpio
// - data and direction per pin
// - per pin pull enable and polarity
// - port-wide port E and debug pullups
// - port S open-drain mode
// - reduced drive on port P high-current pins
// - sticky per pin interrupt flags P L AD
// - glitch filter on interrupt inputs
// - bus clock output gate bit
module prm_pin_routing #(
    parameter FILT_CYC = `PRM_FILT_CYC
) (
    input  wire        CORE_CLK_I,
    input  wire        RESET_N_I,
    // apb slave
    input  wire        PSEL_I,
    input  wire        PENABLE_I,
    input  wire        PWRITE_I,
    input  wire [11:0] PADDR_I,
    input  wire [31:0] PWDATA_I,
    output reg  [31:0] PRDATA_O,
    output reg         PREADY_O,
    output reg         PSLVERR_O,
    output reg         IRQ_O,
    // peripheral side
    input  wire        BUS_CLK_EN_I,
    input  wire        DBG_OUT_I,
    input  wire        DBG_OE_I,
    output reg         DBG_IN_O,
    output reg         MODE_SELECT_SAMPLE_O,
    input  wire        OSC_ACTIVE_I,
    input  wire [3:0]  TIMER_OUT_I,
    input  wire [3:0]  TIMER_OE_I,
    output reg  [3:0]  TIMER_IN_O,
    input  wire        SPI_SS_OUT_I,
    input  wire        SPI_SS_OE_I,
    input  wire        SPI_SCK_OUT_I,
    input  wire        SPI_SCK_OE_I,
    output reg         LIN_PHY_TX_O,
    input  wire        LIN_PHY_RX_I,
    input  wire        LIN_DRIVER_REG_BIT_I,
    input  wire        SERIAL0_TX_I,
    output reg         SERIAL0_RX_O,
    input  wire        PULSE_CHAN7_I,
    input  wire        PULSE_CHAN6_I,
    input  wire        PULSE_CHAN7_EN_I,
    input  wire        PULSE_CHAN6_EN_I,
    // pins
    input  wire        DBG_PIN_I,
    output reg         DBG_PIN_O,
    output reg         DBG_PIN_OE_O,
    output reg         DBG_PIN_PULL_O,
    input  wire [1:0]  PE_PIN_I,
    output reg  [1:0]  PE_PIN_O,
    output reg  [1:0]  PE_PIN_OE_O,
    output reg  [1:0]  PE_PULL_EN_O,
    input  wire [3:0]  PT_PIN_I,
    output reg  [3:0]  PT_PIN_O,
    output reg  [3:0]  PT_PIN_OE_O,
    input  wire [5:0]  PS_PIN_I,
    output reg  [5:0]  PS_PIN_O,
    output reg  [5:0]  PS_PIN_OE_O,
    input  wire [5:0]  PP_PIN_I,
    output reg  [5:0]  PP_PIN_O,
    output reg  [5:0]  PP_PIN_OE_O,
    output reg         PP_REDUCED_DRV_O,
    input  wire [3:0]  PL_PIN_I,
    input  wire [5:0]  PA_PIN_I,
    output reg  [5:0]  PA_PIN_O,
    output reg  [5:0]  PA_PIN_OE_O,
    output reg  [21:0] PULL_EN_O,
    output reg  [21:0] PULL_UP_O,
    output reg         CLK_OUT_PIN_O,
    output reg         CLK_OUT_OE_O
);

    // register storage
    reg  [1:0]  porte_gp_data_reg;
    reg  [1:0]  porte_dir_reg;
    reg  [3:0]  portt_gp_data_reg;
    reg  [3:0]  portt_dir_reg;
    reg  [5:0]  ports_data_reg;
    reg  [5:0]  ports_dir_reg;
    reg  [5:0]  portp_data_reg;
    reg  [5:0]  portp_dir_reg;
    reg  [5:0]  porta_data_reg;
    reg  [5:0]  porta_dir_reg;
    reg  [21:0] pull_en_reg;
    reg  [21:0] pull_up_reg;
    reg  [10:0] misc_reg;
    reg  [3:0]  route_reg;
    reg  [15:0] int_flag_reg;
    reg  [15:0] int_mask_reg;
    reg  [15:0] int_edge_reg;
    reg         in_reset_reg;

    // synchronisers for all pin inputs
    reg  [28:0] sync1_reg;
    reg  [28:0] sync2_reg;
    wire [28:0] pin_raw = {DBG_PIN_I, PE_PIN_I, PT_PIN_I, PS_PIN_I,
                           PL_PIN_I, PP_PIN_I, PA_PIN_I};
    wire [5:0]  pa_sync = sync2_reg[5:0];
    wire [5:0]  pp_sync = sync2_reg[11:6];
    wire [3:0]  pl_sync = sync2_reg[15:12];
    wire [5:0]  ps_sync = sync2_reg[21:16];
    wire [3:0]  pt_sync = sync2_reg[25:22];
    wire        dbg_sync = sync2_reg[28];

    // glitch filter state per interrupt pin
    reg  [15:0] filt_val_reg;
    reg  [15:0] filt_prev_reg;
    reg  [2:0]  filt_cnt_reg [0:15];
    wire [15:0] int_raw = {pa_sync, pl_sync, pp_sync};

    wire        wr_en = PSEL_I & PENABLE_I & PWRITE_I;
    wire        rd_en = PSEL_I & ~PENABLE_I & ~PWRITE_I;
    reg  [31:0] rd_next;
    reg         err_next;
    reg  [15:0] int_event;
    reg  [3:0]  pt_o_next;
    reg  [3:0]  pt_oe_next;
    integer     i;
    integer     j;
    integer     k;

    // two flop synchroniser, free of reset so the mode level
    // on the debug pin is already sampled when reset lifts
    always @(posedge CORE_CLK_I) begin
        sync1_reg <= pin_raw;
        sync2_reg <= sync1_reg;
    end

    // glitch filter: level must hold FILT_CYC cycles
    always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            filt_val_reg  <= 16'h0000;
            filt_prev_reg <= 16'h0000;
            for (i = 0; i < 16; i = i + 1) begin
                filt_cnt_reg[i] <= 3'h0;
            end
        end else begin
            filt_prev_reg <= filt_val_reg;
            for (i = 0; i < 16; i = i + 1) begin
                if (int_raw[i] == filt_val_reg[i]) begin
                    filt_cnt_reg[i] <= 3'h0;
                end else if (filt_cnt_reg[i] == FILT_CYC[2:0] - 3'h1) begin
                    filt_cnt_reg[i] <= 3'h0;
                    filt_val_reg[i] <= int_raw[i];
                end else begin
                    filt_cnt_reg[i] <= filt_cnt_reg[i] + 3'h1;
                end
            end
        end
    end

    // edge select: 1 rising, 0 falling
    always @* begin
        int_event = (int_edge_reg & filt_val_reg & ~filt_prev_reg)
                  | (~int_edge_reg & ~filt_val_reg & filt_prev_reg);
    end

    // register writes and sticky flags
    always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            porte_gp_data_reg <= 2'h0;
            porte_dir_reg     <= 2'h0;
            portt_gp_data_reg <= 4'h0;
            portt_dir_reg     <= 4'h0;
            ports_data_reg    <= 6'h00;
            ports_dir_reg     <= 6'h00;
            portp_data_reg    <= 6'h00;
            portp_dir_reg     <= 6'h00;
            porta_data_reg    <= 6'h00;
            porta_dir_reg     <= 6'h00;
            pull_en_reg       <= `PRM_RST_PULL_EN;
            pull_up_reg       <= `PRM_RST_PULL_UP;
            misc_reg          <= `PRM_RST_MISC;
            route_reg         <= 4'h0;
            int_flag_reg      <= 16'h0000;
            int_mask_reg      <= 16'h0000;
            int_edge_reg      <= 16'h0000;
        end else begin
            if (wr_en) begin
                case (PADDR_I)
                    `PRM_OFS_PORTE_DATA: porte_gp_data_reg <= PWDATA_I[1:0];
                    `PRM_OFS_PORTE_DIR:  porte_dir_reg     <= PWDATA_I[1:0];
                    `PRM_OFS_PORTT_DATA: portt_gp_data_reg <= PWDATA_I[3:0];
                    `PRM_OFS_PORTT_DIR:  portt_dir_reg     <= PWDATA_I[3:0];
                    `PRM_OFS_PORTS_DATA: ports_data_reg    <= PWDATA_I[5:0];
                    `PRM_OFS_PORTS_DIR:  ports_dir_reg     <= PWDATA_I[5:0];
                    `PRM_OFS_PORTP_DATA: portp_data_reg    <= PWDATA_I[5:0];
                    `PRM_OFS_PORTP_DIR:  portp_dir_reg     <= PWDATA_I[5:0];
                    `PRM_OFS_PORTA_DATA: porta_data_reg    <= PWDATA_I[5:0];
                    `PRM_OFS_PORTA_DIR:  porta_dir_reg     <= PWDATA_I[5:0];
                    `PRM_OFS_PULL_EN:    pull_en_reg       <= PWDATA_I[21:0];
                    `PRM_OFS_PULL_UP:    pull_up_reg       <= PWDATA_I[21:0];
                    `PRM_OFS_MISC_CTRL:  misc_reg          <= PWDATA_I[10:0];
                    `PRM_OFS_ROUTE:      route_reg         <= PWDATA_I[3:0];
                    `PRM_OFS_INT_MASK:   int_mask_reg      <= PWDATA_I[15:0];
                    `PRM_OFS_INT_EDGE:   int_edge_reg      <= PWDATA_I[15:0];
                    default: ;
                endcase
            end
            // write one to clear, new event wins
            if (wr_en && PADDR_I == `PRM_OFS_INT_FLAG) begin
                int_flag_reg <= (int_flag_reg & ~PWDATA_I[15:0]) | int_event;
            end else begin
                int_flag_reg <= int_flag_reg | int_event;
            end
        end
    end

    // read mux, captured in setup phase
    always @* begin
        rd_next  = 32'h00000000;
        err_next = 1'b0;
        case (PADDR_I)
            `PRM_OFS_PORTE_DATA: rd_next = {30'h0, porte_gp_data_reg};
            `PRM_OFS_PORTE_DIR:  rd_next = {30'h0, porte_dir_reg};
            `PRM_OFS_PORTT_DATA: rd_next = {28'h0, portt_gp_data_reg};
            `PRM_OFS_PORTT_DIR:  rd_next = {28'h0, portt_dir_reg};
            `PRM_OFS_PORTS_DATA: rd_next = {26'h0, ports_data_reg};
            `PRM_OFS_PORTS_DIR:  rd_next = {26'h0, ports_dir_reg};
            `PRM_OFS_PORTP_DATA: rd_next = {26'h0, portp_data_reg};
            `PRM_OFS_PORTP_DIR:  rd_next = {26'h0, portp_dir_reg};
            `PRM_OFS_PORTA_DATA: rd_next = {26'h0, porta_data_reg};
            `PRM_OFS_PORTA_DIR:  rd_next = {26'h0, porta_dir_reg};
            `PRM_OFS_PULL_EN:    rd_next = {10'h0, pull_en_reg};
            `PRM_OFS_PULL_UP:    rd_next = {10'h0, pull_up_reg};
            `PRM_OFS_MISC_CTRL:  rd_next = {21'h0, misc_reg};
            `PRM_OFS_ROUTE:      rd_next = {28'h0, route_reg};
            `PRM_OFS_INT_FLAG:   rd_next = {16'h0, int_flag_reg};
            `PRM_OFS_INT_MASK:   rd_next = {16'h0, int_mask_reg};
            `PRM_OFS_INT_EDGE:   rd_next = {16'h0, int_edge_reg};
            `PRM_OFS_PIN_IN:     rd_next = {3'h0, sync2_reg};
            `PRM_OFS_STATUS:     rd_next = {31'h0, MODE_SELECT_SAMPLE_O};
            default:             err_next = 1'b1;
        endcase
    end

    // apb answer: no wait state, ready and data in first access cycle
    always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            PRDATA_O  <= 32'h00000000;
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
            IRQ_O     <= 1'b0;
        end else begin
            PREADY_O  <= PSEL_I & ~PENABLE_I;
            PSLVERR_O <= PSEL_I & ~PENABLE_I & err_next;
            if (rd_en) begin
                PRDATA_O <= rd_next;
            end
            IRQ_O <= |(int_flag_reg & int_mask_reg);
        end
    end

    // port T muxing, highest ranked active function first
    always @* begin
        for (j = 0; j < 4; j = j + 1) begin
            pt_oe_next[j] = TIMER_OE_I[j] | portt_dir_reg[j];
            pt_o_next[j]  = TIMER_OE_I[j] ? TIMER_OUT_I[j] : portt_gp_data_reg[j];
        end
        // pin 3: routed slave select, then lin transmit input
        if (route_reg[`PRM_RT_SPI_T]) begin
            pt_oe_next[3] = SPI_SS_OE_I;
            pt_o_next[3]  = SPI_SS_OUT_I;
        end else if (route_reg[`PRM_RT_LIN_T]) begin
            pt_oe_next[3] = 1'b0;
            pt_o_next[3]  = 1'b0;
        end
        // pin 2: routed spi clock, then lin receive output
        if (route_reg[`PRM_RT_SPI_T]) begin
            pt_oe_next[2] = SPI_SCK_OE_I;
            pt_o_next[2]  = SPI_SCK_OUT_I;
        end else if (route_reg[`PRM_RT_LIN_T]) begin
            pt_oe_next[2] = 1'b1;
            pt_o_next[2]  = LIN_PHY_RX_I;
        end
        // pin 1 priority chain
        if (route_reg[`PRM_RT_LINDRV_T1]) begin
            pt_oe_next[1] = 1'b1;
            pt_o_next[1]  = LIN_DRIVER_REG_BIT_I;
        end else if (route_reg[`PRM_RT_SCI0_T]) begin
            pt_oe_next[1] = 1'b1;
            pt_o_next[1]  = SERIAL0_TX_I;
        end else if (PULSE_CHAN7_EN_I) begin
            pt_oe_next[1] = 1'b1;
            pt_o_next[1]  = PULSE_CHAN7_I;
        end
        // pin 0 priority chain
        if (route_reg[`PRM_RT_SCI0_T]) begin
            pt_oe_next[0] = 1'b0;
            pt_o_next[0]  = 1'b0;
        end else if (PULSE_CHAN6_EN_I) begin
            pt_oe_next[0] = 1'b1;
            pt_o_next[0]  = PULSE_CHAN6_I;
        end
    end

    // reset window and mode sample capture
    always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            in_reset_reg         <= 1'b1;
            MODE_SELECT_SAMPLE_O <= 1'b0;
        end else begin
            in_reset_reg <= 1'b0;
            if (in_reset_reg) begin
                MODE_SELECT_SAMPLE_O <= dbg_sync;
            end
        end
    end

    // registered pin drives
    always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            DBG_PIN_O        <= 1'b0;
            DBG_PIN_OE_O     <= 1'b0;
            DBG_PIN_PULL_O   <= 1'b1;
            DBG_IN_O         <= 1'b1;
            PE_PIN_O         <= 2'h0;
            PE_PIN_OE_O      <= 2'h0;
            PE_PULL_EN_O     <= 2'h3;
            PT_PIN_O         <= 4'h0;
            PT_PIN_OE_O      <= 4'h0;
            PS_PIN_O         <= 6'h00;
            PS_PIN_OE_O      <= 6'h00;
            PP_PIN_O         <= 6'h00;
            PP_PIN_OE_O      <= 6'h00;
            PP_REDUCED_DRV_O <= 1'b0;
            PA_PIN_O         <= 6'h00;
            PA_PIN_OE_O      <= 6'h00;
            PULL_EN_O        <= 22'h000000;
            PULL_UP_O        <= 22'h000000;
            CLK_OUT_PIN_O    <= 1'b0;
            CLK_OUT_OE_O     <= 1'b0;
            TIMER_IN_O       <= 4'h0;
            LIN_PHY_TX_O     <= 1'b1;
            SERIAL0_RX_O     <= 1'b1;
        end else begin
            // debug wire only after reset window
            DBG_PIN_OE_O   <= ~in_reset_reg & DBG_OE_I;
            DBG_PIN_O      <= DBG_OUT_I;
            DBG_IN_O       <= dbg_sync;
            DBG_PIN_PULL_O <= misc_reg[`PRM_MISC_DBG_PULL];
            // oscillator owns port E when active
            PE_PIN_OE_O  <= OSC_ACTIVE_I ? 2'h0 : porte_dir_reg;
            PE_PIN_O     <= porte_gp_data_reg;
            PE_PULL_EN_O <= (misc_reg[`PRM_MISC_PE_PULL] & ~OSC_ACTIVE_I) ? 2'h3 : 2'h0;
            PT_PIN_O     <= pt_o_next;
            PT_PIN_OE_O  <= pt_oe_next;
            TIMER_IN_O   <= pt_sync;
            LIN_PHY_TX_O <= route_reg[`PRM_RT_LIN_T] ? pt_sync[3] : 1'b1;
            SERIAL0_RX_O <= route_reg[`PRM_RT_SCI0_T] ? pt_sync[0] : 1'b1;
            // port S open drain drives low only
            for (k = 0; k < 6; k = k + 1) begin
                if (misc_reg[`PRM_MISC_OPEN_DRAIN + k]) begin
                    PS_PIN_O[k]    <= 1'b0;
                    PS_PIN_OE_O[k] <= ports_dir_reg[k] & ~ports_data_reg[k];
                end else begin
                    PS_PIN_O[k]    <= ports_data_reg[k];
                    PS_PIN_OE_O[k] <= ports_dir_reg[k];
                end
            end
            PP_PIN_O         <= portp_data_reg;
            PP_PIN_OE_O      <= portp_dir_reg;
            PP_REDUCED_DRV_O <= misc_reg[`PRM_MISC_REDUCED_DRV];
            PA_PIN_O         <= porta_data_reg;
            PA_PIN_OE_O      <= porta_dir_reg;
            PULL_EN_O        <= pull_en_reg;
            PULL_UP_O        <= pull_up_reg;
            // clock out pin released while bit clear
            CLK_OUT_OE_O  <= misc_reg[`PRM_MISC_CLK_OUT];
            CLK_OUT_PIN_O <= misc_reg[`PRM_MISC_CLK_OUT] & BUS_CLK_EN_I;
        end
    end

endmodule // prm_pin_routing

// ### verif/prm_pin_partner.sv
`timescale 1ns/100ps
module prm_pin_partner #(
    parameter W = 25
) (
    input  wire         clk_i,
    input  wire [W-1:0] dev_o_i,
    input  wire [W-1:0] dev_oe_i,
    input  wire [W-1:0] far_o_i,
    input  wire [W-1:0] far_oe_i,
    input  wire [W-1:0] pu_i,
    input  wire [W-1:0] pd_i,
    output wire [W-1:0] pin_o
);
    reg [W-1:0] float_reg = {W{1'b0}};

    // undriven unpulled lines toggle so no stale level survives
    always @(posedge clk_i) begin
        float_reg <= ~float_reg;
    end

    // far side and device drive as a wired-or; pulls act only where neither drives
    assign pin_o = (dev_oe_i & dev_o_i) | (far_oe_i & far_o_i)
                 | (~dev_oe_i & ~far_oe_i & (pu_i | (~pd_i & float_reg)));
endmodule // prm_pin_partner

// ### verif/prm_pin_routing_sva.sv
`timescale 1ns/100ps
module prm_pin_routing_chk (
    input wire        CORE_CLK_I,
    input wire        RESET_N_I,
    input wire        PSEL_I,
    input wire        PENABLE_I,
    input wire        PWRITE_I,
    input wire [31:0] PRDATA_O,
    input wire        PREADY_O,
    input wire        BUS_CLK_EN_I,
    input wire        CLK_OUT_PIN_O,
    input wire        CLK_OUT_OE_O,
    input wire        OSC_ACTIVE_I,
    input wire [1:0]  PE_PIN_OE_O,
    input wire [1:0]  PE_PULL_EN_O,
    input wire        PULSE_CHAN7_EN_I,
    input wire [3:0]  TIMER_OE_I,
    input wire [3:0]  PT_PIN_OE_O,
    input wire        DBG_PIN_I,
    input wire        DBG_PIN_OE_O,
    input wire        MODE_SELECT_SAMPLE_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESET_N_I);

    // bus answer timing and read data holding
    chk_ready_setup: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
        else $error("no ready after setup");
    chk_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready held too long");
    chk_rdata_hold: assert property (!(PSEL_I && !PENABLE_I && !PWRITE_I) |=> $stable(PRDATA_O))
        else $error("read data moved");
    // pin ownership and priority
    chk_clk_gate: assert property (CLK_OUT_OE_O |-> CLK_OUT_PIN_O == $past(BUS_CLK_EN_I))
        else $error("clock out not following bus clock");
    chk_osc_owns: assert property (OSC_ACTIVE_I |=> PE_PIN_OE_O == 2'b00 && PE_PULL_EN_O == 2'b00)
        else $error("port E driven while oscillator owns it");
    chk_t1_drive: assert property (PULSE_CHAN7_EN_I || TIMER_OE_I[1] |=> PT_PIN_OE_O[1])
        else $error("pin T1 not driven");
    // debug pin around reset release
    chk_dbg_quiet: assert property ($rose(RESET_N_I) |-> !DBG_PIN_OE_O ##1 !DBG_PIN_OE_O)
        else $error("debug pin driven too early");
    chk_mode_take: assert property ($rose(RESET_N_I) |=> MODE_SELECT_SAMPLE_O == $past(DBG_PIN_I, 3))
        else $error("mode sample wrong");
    chk_mode_hold: assert property ($past(RESET_N_I, 2) |-> $stable(MODE_SELECT_SAMPLE_O))
        else $error("mode sample changed");
endmodule // prm_pin_routing_chk

bind prm_pin_routing prm_pin_routing_chk u_chk (.*);

// ### verif/tb_top.sv
`timescale 1ns/100ps
`include "prm_map.vh"
module tb_top;
    localparam FILT = 3;
    logic CORE_CLK_I = 0, RESET_N_I = 0, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0;
    logic BUS_CLK_EN_I = 0, DBG_OUT_I = 0, DBG_OE_I = 0, OSC_ACTIVE_I = 0, LIN_PHY_RX_I = 0;
    logic SPI_SS_OUT_I = 0, SPI_SS_OE_I = 0, SPI_SCK_OUT_I = 0, SPI_SCK_OE_I = 0;
    logic LIN_DRIVER_REG_BIT_I = 0, SERIAL0_TX_I = 0, PULSE_CHAN7_I = 0, PULSE_CHAN6_I = 0;
    logic PULSE_CHAN7_EN_I = 0, PULSE_CHAN6_EN_I = 0, rerr;
    logic [11:0] PADDR_I = 0;
    logic [31:0] PWDATA_I = 0, rdat, rnd = 32'h9FF9;
    logic [3:0]  TIMER_OUT_I = 0, TIMER_OE_I = 0, PL_PIN_I = 0;
    logic [24:0] far_d = 25'h1000000, far_oe = 25'h1000000;
    wire PREADY_O, PSLVERR_O, IRQ_O, DBG_IN_O, MODE_SELECT_SAMPLE_O, LIN_PHY_TX_O, SERIAL0_RX_O;
    wire DBG_PIN_I, DBG_PIN_O, DBG_PIN_OE_O, DBG_PIN_PULL_O, PP_REDUCED_DRV_O;
    wire CLK_OUT_PIN_O, CLK_OUT_OE_O;
    wire [31:0] PRDATA_O;
    wire [1:0]  PE_PIN_I, PE_PIN_O, PE_PIN_OE_O, PE_PULL_EN_O;
    wire [3:0]  TIMER_IN_O, PT_PIN_I, PT_PIN_O, PT_PIN_OE_O;
    wire [5:0]  PS_PIN_I, PS_PIN_O, PS_PIN_OE_O, PP_PIN_I, PP_PIN_O, PP_PIN_OE_O;
    wire [5:0]  PA_PIN_I, PA_PIN_O, PA_PIN_OE_O;
    wire [21:0] PULL_EN_O, PULL_UP_O;
    wire [21:0] pu = PULL_EN_O & PULL_UP_O;
    wire [21:0] pd = PULL_EN_O & ~PULL_UP_O;
    int errors = 0, n_tests = 0;

    prm_pin_routing #(.FILT_CYC(FILT)) dut (.*);

    // board side: pins bit 24 debug, 23:22 E, 21:18 T, 17:12 S, 11:6 P, 5:0 AD
    prm_pin_partner #(.W(25)) u_far (.clk_i(CORE_CLK_I),
        .dev_o_i({DBG_PIN_O, PE_PIN_O, PT_PIN_O, PS_PIN_O, PP_PIN_O, PA_PIN_O}),
        .dev_oe_i({DBG_PIN_OE_O, PE_PIN_OE_O, PT_PIN_OE_O, PS_PIN_OE_O, PP_PIN_OE_O, PA_PIN_OE_O}),
        .far_o_i(far_d), .far_oe_i(far_oe),
        .pu_i({DBG_PIN_PULL_O, PE_PULL_EN_O, pu[3:0], pu[9:4], pu[15:10], pu[21:16]}),
        .pd_i({3'b000, pd[3:0], pd[9:4], pd[15:10], pd[21:16]}),
        .pin_o({DBG_PIN_I, PE_PIN_I, PT_PIN_I, PS_PIN_I, PP_PIN_I, PA_PIN_I}));

    // clock
    initial begin
        forever #5 CORE_CLK_I = ~CORE_CLK_I;
    end

    task end_sim;
        if (errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one bus transfer; data and error taken at the ready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge CORE_CLK_I);
        PSEL_I <= 1;
        PWRITE_I <= w;
        PADDR_I <= a;
        PWDATA_I <= d;
        @(posedge CORE_CLK_I);
        PENABLE_I <= 1;
        do begin
            @(posedge CORE_CLK_I);
        end while (PREADY_O !== 1'b1);
        rdat = PRDATA_O;
        rerr = PSLVERR_O;
        PSEL_I <= 0;
        PENABLE_I <= 0;
    endtask

    task rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk(rdat, e);
    endtask

    task settle;
        repeat (5) @(posedge CORE_CLK_I);
    endtask

    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // expected port T {oe, driven level}, lowest rank applied first
    function logic [7:0] exp_pt(input logic [3:0] rt, input logic [3:0] d, input logic [3:0] dir);
        logic [3:0] oe, o;
        oe = dir | TIMER_OE_I;
        o = (d & ~TIMER_OE_I) | (TIMER_OUT_I & TIMER_OE_I);
        if (PULSE_CHAN7_EN_I) {oe[1], o[1]} = {1'b1, PULSE_CHAN7_I};
        if (PULSE_CHAN6_EN_I) {oe[0], o[0]} = {1'b1, PULSE_CHAN6_I};
        if (rt[3]) {oe[1], o[1], oe[0]} = {1'b1, SERIAL0_TX_I, 1'b0};
        if (rt[2]) {oe[1], o[1]} = {1'b1, LIN_DRIVER_REG_BIT_I};
        if (rt[1]) {oe[3], oe[2], o[2]} = {2'b01, LIN_PHY_RX_I};
        if (rt[0]) {oe[3:2], o[3:2]} = {2'b11, SPI_SS_OUT_I, SPI_SCK_OUT_I};
        return {oe, o & oe};
    endfunction

    // watchdog
    initial begin
        #100000;
        errors++;
        end_sim;
    end

    initial begin
        repeat (16) @(posedge CORE_CLK_I);
        RESET_N_I <= 1;
        @(posedge CORE_CLK_I);
        far_oe <= 0;
        settle;
        chk(MODE_SELECT_SAMPLE_O, 1);
        chk(DBG_IN_O, 1);
        chk({PE_PULL_EN_O, DBG_PIN_PULL_O, PE_PIN_OE_O, PT_PIN_OE_O}, 9'h1C0);
        rdchk(`PRM_OFS_MISC_CTRL, 32'h3);
        rdchk(`PRM_OFS_STATUS, 32'h1);
        rdchk(12'h100, 32'h0);
        chk(rerr, 1);
        // debug wire both ways
        DBG_OE_I <= 1;
        settle;
        chk({DBG_PIN_OE_O, DBG_PIN_O}, 2'b10);
        DBG_OE_I <= 0;
        far_oe <= 25'h1000000;
        far_d <= 0;
        settle;
        chk(DBG_IN_O, 0);
        // port E data, direction and oscillator takeover
        apb(1, `PRM_OFS_PORTE_DATA, 32'h2);
        apb(1, `PRM_OFS_PORTE_DIR, 32'h3);
        settle;
        chk({PE_PIN_OE_O, PE_PIN_O}, 4'hE);
        OSC_ACTIVE_I <= 1;
        settle;
        chk({PE_PIN_OE_O, PE_PULL_EN_O}, 4'h0);
        OSC_ACTIVE_I <= 0;
        // pulls, open drain, drive strength, clock out
        repeat (6) begin
            rnd = lfsr(rnd);
            BUS_CLK_EN_I <= rnd[31];
            apb(1, `PRM_OFS_MISC_CTRL, {22'h0, rnd[9:0]});
            apb(1, `PRM_OFS_PORTS_DATA, {26'h0, rnd[15:10]});
            apb(1, `PRM_OFS_PORTS_DIR, {26'h0, rnd[21:16]});
            apb(1, `PRM_OFS_PULL_EN, {10'h0, rnd[31:10]});
            apb(1, `PRM_OFS_PULL_UP, {10'h0, rnd[21:0]});
            apb(1, `PRM_OFS_PORTP_DATA, {26'h0, rnd[15:10]});
            apb(1, `PRM_OFS_PORTP_DIR, {26'h0, rnd[21:16]});
            apb(1, `PRM_OFS_PORTA_DATA, {26'h0, rnd[21:16]});
            apb(1, `PRM_OFS_PORTA_DIR, {26'h0, rnd[15:10]});
            settle;
            chk(PULL_EN_O, rnd[31:10]);
            chk(PULL_UP_O, rnd[21:0]);
            rdchk(`PRM_OFS_PULL_EN, {10'h0, rnd[31:10]});
            chk({PE_PULL_EN_O, DBG_PIN_PULL_O, PP_REDUCED_DRV_O, CLK_OUT_OE_O,
                 CLK_OUT_PIN_O & CLK_OUT_OE_O},
                {{2{rnd[0]}}, rnd[1], rnd[8], rnd[9], rnd[9] & rnd[31]});
            chk({PS_PIN_OE_O, PS_PIN_O & PS_PIN_OE_O}, {rnd[21:16] & ~(rnd[7:2] & rnd[15:10]),
                rnd[15:10] & ~rnd[7:2] & rnd[21:16]});
            chk({PP_PIN_OE_O, PP_PIN_O, PA_PIN_OE_O, PA_PIN_O},
                {rnd[21:10], rnd[15:10], rnd[21:16]});
        end
        apb(1, `PRM_OFS_MISC_CTRL, 32'h3);
        apb(1, `PRM_OFS_PORTP_DIR, 32'h0);
        apb(1, `PRM_OFS_PORTA_DIR, 32'h0);
        // port T output ranking under random routing
        SPI_SS_OE_I <= 1;
        SPI_SCK_OE_I <= 1;
        repeat (24) begin
            rnd = lfsr(rnd);
            {TIMER_OUT_I, TIMER_OE_I, PULSE_CHAN7_I, PULSE_CHAN6_I, PULSE_CHAN7_EN_I,
             PULSE_CHAN6_EN_I, LIN_DRIVER_REG_BIT_I, SERIAL0_TX_I, LIN_PHY_RX_I,
             SPI_SS_OUT_I, SPI_SCK_OUT_I} <= rnd[16:0];
            far_d <= {3'b000, rnd[20:17], 18'h0};
            far_oe <= {3'h0, rnd[26] & ~rnd[25], 2'h0, rnd[28], 18'h0};
            apb(1, `PRM_OFS_ROUTE, {28'h0, rnd[28:25]});
            apb(1, `PRM_OFS_PORTT_DATA, {28'h0, rnd[20:17]});
            apb(1, `PRM_OFS_PORTT_DIR, {28'h0, rnd[24:21]});
            settle;
            chk({PT_PIN_OE_O, PT_PIN_O & PT_PIN_OE_O}, exp_pt(rnd[28:25], rnd[20:17], rnd[24:21]));
            chk(SERIAL0_RX_O, rnd[28] ? rnd[17] : 1'b1);
            chk(LIN_PHY_TX_O, rnd[26] ? (rnd[25] ? rnd[1] : rnd[20]) : 1'b1);
        end
        // pin interrupts: glitch, sticky flag, mask, clear
        far_d <= 0;
        far_oe <= 25'hFFF;
        apb(1, `PRM_OFS_INT_EDGE, 32'hFFFF);
        apb(1, `PRM_OFS_INT_MASK, 32'h1);
        settle;
        apb(1, `PRM_OFS_INT_FLAG, 32'hFFFF);
        far_d <= 25'h40;
        PL_PIN_I <= 4'h1;
        repeat (FILT - 1) @(posedge CORE_CLK_I);
        far_d <= 0;
        PL_PIN_I <= 4'h0;
        settle;
        rdchk(`PRM_OFS_INT_FLAG, 32'h0);
        chk(IRQ_O, 0);
        far_d <= 25'h40;
        PL_PIN_I <= 4'h1;
        repeat (FILT + 6) @(posedge CORE_CLK_I);
        far_d <= 0;
        PL_PIN_I <= 4'h0;
        settle;
        rdchk(`PRM_OFS_INT_FLAG, 32'h41);
        chk(IRQ_O, 1);
        apb(1, `PRM_OFS_INT_MASK, 32'h0);
        settle;
        chk(IRQ_O, 0);
        apb(1, `PRM_OFS_INT_FLAG, 32'h1);
        rdchk(`PRM_OFS_INT_FLAG, 32'h40);
        end_sim;
    end
endmodule // tb_top
